// ===== core/cisa_pkg.sv
// constants, types and helpers shared by the jump and byte-load execute logic
package cisa_pkg;

    // register map, byte addresses of aligned 32-bit words
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_PC = 12'h004;
    localparam logic [11:0] OFS_MODE = 12'h008;
    localparam logic [11:0] OFS_INSTR = 12'h00C;
    localparam logic [11:0] OFS_STATUS = 12'h010;
    localparam logic [11:0] OFS_MASK = 12'h014;
    localparam logic [11:0] OFS_STATE = 12'h018;
    localparam logic [11:0] OFS_RETIRED = 12'h01C;
    localparam logic [11:0] OFS_GPR = 12'h080;

    // control register fields
    localparam int CTRL_MSB_FIRST_BIT = 0;
    localparam int CTRL_BYTE_SWAP_BIT = 1;

    // status and mask fields
    localparam int ST_DONE_BIT = 0;
    localparam int ST_ADDR_ERR_BIT = 1;
    localparam int ST_BAD_OP_BIT = 2;
    localparam int STATUS_W = 3;

    // reset values
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic MODE_RESET = 1'b0;
    localparam logic [STATUS_W-1:0] MASK_RESET = 3'h0;

    // instruction encodings
    localparam logic [4:0] REG_REG_MAJOR_OP = 5'h1D;
    localparam logic [4:0] JUMP_FUNC = 5'h00;
    localparam logic [4:0] EXTEND_PREFIX = 5'h1E;
    localparam logic [4:0] BYTE_LOAD_OP = 5'h10;
    // major opcode of the full-width mode-swap call; plain default
    localparam logic [5:0] MODE_SWAP_CALL_OP = 6'h1D;
    localparam int DELAY_SKIP_BIT = 7;
    localparam int LINK_BIT = 6;
    localparam int RETURN_SOURCE_BIT = 5;

    // architectural constants
    localparam logic [4:0] LINK_REG = 5'd31;
    localparam logic [31:0] LEN_SHORT = 32'h0000_0002;
    localparam logic [31:0] LEN_LONG = 32'h0000_0004;
    localparam logic [31:0] SWAP_LINK_OFS = 32'h0000_0008;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01
    } exec_state_t;

    // 3-bit register field to architectural register
    function automatic logic [4:0] reg_map(input logic [2:0] f);
        reg_map = (f == 3'd0) ? 5'd16 : (f == 3'd1) ? 5'd17 : {2'b00, f};
    endfunction

endpackage

// ===== core/reg_jump_unit.sv
// decode and target forming for the register-indirect jump family
`timescale 1ns/1ns
module reg_jump_unit
    import cisa_pkg::*;
(
    // instruction and state
    input wire logic [15:0] instr,
    input wire logic [31:0] pc,
    input wire logic compressed_mode_flag,
    // source register values
    input wire logic [31:0] src_return,
    input wire logic [31:0] src_base,
    // decoded result
    output logic is_jump,
    output logic delay_skip_flag,
    output logic link,
    output logic [31:0] target,
    output logic target_mode,
    output logic [31:0] link_value
);
    logic [31:0] src;
    logic [31:0] ret;

    always_comb begin
        is_jump = (instr[15:11] == REG_REG_MAJOR_OP) && (instr[4:0] == JUMP_FUNC);
        delay_skip_flag = instr[DELAY_SKIP_BIT];
        link = instr[LINK_BIT];
        src = instr[RETURN_SOURCE_BIT] ? src_return : src_base;
        target = {src[31:1], 1'b0};
        target_mode = src[0];
        // return past the slot when delayed, past the jump when compact
        ret = pc + (delay_skip_flag ? LEN_SHORT : LEN_LONG);
        link_value = {ret[31:1], compressed_mode_flag};
    end

endmodule

// ===== core/byte_load_unit.sv
// effective address, lane choice and sign extension for the signed byte load
`timescale 1ns/1ns
module byte_load_unit
    import cisa_pkg::*;
(
    // instruction and base
    input wire logic [31:0] instr,
    input wire logic extended,
    input wire logic [31:0] base,
    // endianness controls
    input wire logic msb_first_core,
    input wire logic user_byte_swap,
    // returned word and lane latched at issue
    input wire logic [31:0] rdata,
    input wire logic [1:0] lane_sel,
    // results
    output logic [31:0] phys_addr,
    output logic [1:0] lane,
    output logic [31:0] load_value
);
    logic [31:0] offset;
    logic [31:0] vaddr;
    logic [7:0] b;

    always_comb begin
        if (extended) begin
            offset = {{16{instr[20]}}, instr[20:16], instr[26:21], instr[4:0]};
        end else begin
            offset = {27'h0, instr[4:0]};
        end
        vaddr = base + offset;
        // translation is identity apart from the byte-swap flip of bits 1:0; no alignment test on purpose
        phys_addr = {vaddr[31:2], vaddr[1:0] ^ {2{user_byte_swap}}};
        lane = vaddr[1:0] ^ {2{msb_first_core}};
        b = rdata[8*lane_sel +: 8];
        load_value = {{24{b[7]}}, b};
    end

endmodule

// ===== core/cisa_exec.sv
// execute stage for mode-swap call, register jumps and signed byte load, with APB access
`timescale 1ns/1ns
// Summary of operation
// - The full-width mode-swap call sets register 31 to pc plus eight, then jumps and flips the mode flag.
// - Mode-swap upper target bits come from the slot, so the last word of a 256 MB region reaches the next one.
// - The delayed return-register jump loads pc from register 31 after one delay-slot instruction.
// - The delayed base-register jump loads pc from the 3-bit base field's register after one slot instruction.
// - The compact register jumps redirect at once and the sequentially next instruction is not executed.
// - Every register jump loads the compressed-mode flag from bit 0 of its source.
// - Every register jump clears bit 0 of the new pc, so an odd source never faults by itself.
// - A source with bit 0 clear and bit 1 set faults with an address error at target fetch, not at the jump.
// - Register jumps decode from major opcode 11101, function 00000, with skip, link and source bits 7, 6, 5.
// - A branch or jump in a delay slot has no defined result and software must avoid it.
// - The short byte load zero-extends its 5-bit offset and adds the base register to form the address.
// - An extend prefix gives the byte load a sign-extended 16-bit offset built from prefix and short fields.
// - The loaded byte is sign-extended and written to the register chosen by bits 7:5.
// - User byte-swap flips the physical low address bits; the lane is the low address bits flipped by core order.
module cisa_exec
    import cisa_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // data memory
    output logic dmem_req,
    output logic [31:0] dmem_addr,
    input wire logic dmem_ack,
    input wire logic [31:0] dmem_rdata,
    // core state view
    output logic [31:0] pc_out,
    output logic compressed_mode_flag,
    output logic irq
);
    typedef struct packed {
        exec_state_t st;
        logic [31:0] pc;
        logic mode;
        logic msb_first;
        logic byte_swap;
        logic pend;
        logic [31:0] pend_pc;
        logic pend_mode;
        logic [STATUS_W-1:0] status;
        logic [STATUS_W-1:0] mask;
        logic [4:0] ld_dst;
        logic [1:0] ld_lane;
        logic [31:0] ld_len;
        logic req;
        logic [31:0] maddr;
        logic [31:0] retired;
        logic [31:0] prdata;
        logic pslverr;
        logic [31:0][31:0] gpr;
    } exec_regs_t;

    exec_regs_t r_q;
    exec_regs_t r_d;

    logic [31:0] cur_instr;
    logic extended;
    logic [31:0] load_base;
    logic [31:0] jump_base;
    logic is_jump;
    logic skip;
    logic link;
    logic [31:0] jtarget;
    logic jmode;
    logic [31:0] link_value;
    logic [31:0] phys_addr;
    logic [1:0] lane;
    logic [31:0] load_value;

    assign cur_instr = pwdata;
    assign extended = r_q.mode && (cur_instr[31:27] == EXTEND_PREFIX);
    assign load_base = r_q.gpr[reg_map(cur_instr[10:8])];
    assign jump_base = r_q.gpr[reg_map(cur_instr[10:8])];

    reg_jump_unit u_jump (
        .instr(cur_instr[15:0]),
        .pc(r_q.pc),
        .compressed_mode_flag(r_q.mode),
        .src_return(r_q.gpr[LINK_REG]),
        .src_base(jump_base),
        .is_jump(is_jump),
        .delay_skip_flag(skip),
        .link(link),
        .target(jtarget),
        .target_mode(jmode),
        .link_value(link_value)
    );

    byte_load_unit u_load (
        .instr(cur_instr),
        .extended(extended),
        .base(load_base),
        .msb_first_core(r_q.msb_first),
        .user_byte_swap(r_q.byte_swap),
        .rdata(dmem_rdata),
        .lane_sel(r_q.ld_lane),
        .phys_addr(phys_addr),
        .lane(lane),
        .load_value(load_value)
    );

    logic setup;
    logic wr_access;
    logic busy;
    logic start;
    logic [31:0] rd_val;
    logic hit;
    logic [STATUS_W-1:0] set;
    logic [STATUS_W-1:0] clr;
    logic [31:0] seq_pc;
    logic [31:0] slot_pc;
    logic [4:0] gidx;

    always_comb begin
        r_d = r_q;
        set = '0;
        clr = '0;
        start = 1'b0;
        rd_val = 32'h0000_0000;
        hit = 1'b1;
        seq_pc = 32'h0000_0000;
        slot_pc = 32'h0000_0000;
        gidx = paddr[6:2];
        setup = psel && !penable;
        wr_access = psel && penable && pwrite;
        busy = (r_q.st != ST_IDLE);

        // read data is captured in the setup cycle so the bus sees a flop
        if (paddr[11:7] == OFS_GPR[11:7]) begin
            rd_val = (gidx == 5'd0) ? 32'h0000_0000 : r_q.gpr[gidx];
        end else begin
            case (paddr)
                OFS_CTRL: rd_val = {30'h0, r_q.byte_swap, r_q.msb_first};
                OFS_PC: rd_val = r_q.pc;
                OFS_MODE: rd_val = {31'h0, r_q.mode};
                OFS_INSTR: rd_val = 32'h0000_0000;
                OFS_STATUS: rd_val = {29'h0, r_q.status};
                OFS_MASK: rd_val = {29'h0, r_q.mask};
                OFS_STATE: rd_val = {30'h0, r_q.pend, busy};
                OFS_RETIRED: rd_val = r_q.retired;
                default: hit = 1'b0;
            endcase
        end
        if (setup) begin
            r_d.prdata = rd_val;
            r_d.pslverr = !hit || (paddr[1:0] != 2'b00);
        end

        // architectural state other than status clears is frozen to software while a load is out
        if (wr_access && !busy) begin
            if (paddr[11:7] == OFS_GPR[11:7]) begin
                // a misaligned word is refused like an unmapped one
                if (gidx != 5'd0 && paddr[1:0] == 2'b00) begin
                    r_d.gpr[gidx] = pwdata;
                end
            end else begin
                case (paddr)
                    OFS_CTRL: begin
                        r_d.msb_first = pwdata[CTRL_MSB_FIRST_BIT];
                        r_d.byte_swap = pwdata[CTRL_BYTE_SWAP_BIT];
                    end
                    OFS_PC: r_d.pc = pwdata;
                    OFS_MODE: r_d.mode = pwdata[0];
                    OFS_INSTR: start = 1'b1;
                    OFS_MASK: r_d.mask = pwdata[STATUS_W-1:0];
                    default: begin
                    end
                endcase
            end
        end
        if (wr_access && paddr == OFS_STATUS) begin
            clr = pwdata[STATUS_W-1:0];
        end

        // pc after this instruction: pending target once the slot retires
        slot_pc = r_q.pc + LEN_LONG;
        seq_pc = r_q.pend ? r_q.pend_pc : (r_q.pc + (extended || !r_q.mode ? LEN_LONG : LEN_SHORT));

        unique case (r_q.st)
            ST_IDLE: begin
                if (start) begin
                    if (!r_q.mode && r_q.pc[1]) begin
                        // fault is taken at fetch of the bad target, nothing executes
                        set[ST_ADDR_ERR_BIT] = 1'b1;
                    end else if (!r_q.mode) begin
                        if (cur_instr[31:26] == MODE_SWAP_CALL_OP) begin
                            r_d.gpr[LINK_REG] = r_q.pc + SWAP_LINK_OFS;
                            r_d.pc = seq_pc;
                            r_d.pend = 1'b1;
                            r_d.pend_pc = {slot_pc[31:28], cur_instr[25:0], 2'b00};
                            r_d.pend_mode = !r_q.mode;
                            set[ST_DONE_BIT] = 1'b1;
                            r_d.retired = r_q.retired + 32'h0000_0001;
                        end else begin
                            set[ST_BAD_OP_BIT] = 1'b1;
                        end
                    end else if (!extended && is_jump) begin
                        if (link) begin
                            r_d.gpr[LINK_REG] = link_value;
                        end
                        if (skip) begin
                            // compact: no slot, sequential successor is skipped
                            r_d.pc = jtarget;
                            r_d.mode = jmode;
                            r_d.pend = 1'b0;
                        end else begin
                            // a jump sitting in a slot takes the pending target now and becomes pending itself
                            r_d.pc = seq_pc;
                            r_d.mode = r_q.pend ? r_q.pend_mode : r_q.mode;
                            r_d.pend = 1'b1;
                            r_d.pend_pc = jtarget;
                            r_d.pend_mode = jmode;
                        end
                        set[ST_DONE_BIT] = 1'b1;
                        r_d.retired = r_q.retired + 32'h0000_0001;
                    end else if (cur_instr[15:11] == BYTE_LOAD_OP) begin
                        r_d.st = ST_LOAD;
                        r_d.req = 1'b1;
                        r_d.maddr = phys_addr;
                        r_d.ld_lane = lane;
                        r_d.ld_dst = reg_map(cur_instr[7:5]);
                        r_d.ld_len = extended ? LEN_LONG : LEN_SHORT;
                    end else begin
                        set[ST_BAD_OP_BIT] = 1'b1;
                    end
                end
            end
            ST_LOAD: begin
                if (dmem_ack) begin
                    r_d.req = 1'b0;
                    r_d.st = ST_IDLE;
                    if (r_q.ld_dst != 5'd0) begin
                        r_d.gpr[r_q.ld_dst] = load_value;
                    end
                    if (r_q.pend) begin
                        r_d.pc = r_q.pend_pc;
                        r_d.mode = r_q.pend_mode;
                        r_d.pend = 1'b0;
                    end else begin
                        r_d.pc = r_q.pc + r_q.ld_len;
                    end
                    set[ST_DONE_BIT] = 1'b1;
                    r_d.retired = r_q.retired + 32'h0000_0001;
                end
            end
        endcase

        // a slot that retires without a jump of its own takes the pending redirect
        if (start && r_q.pend && r_d.st == ST_IDLE && !(r_q.mode && !extended && is_jump) && !set[ST_ADDR_ERR_BIT]
            && !set[ST_BAD_OP_BIT] && r_q.mode) begin
            r_d.mode = r_q.pend_mode;
            r_d.pend = 1'b0;
        end

        // hardware set wins over a software clear in the same cycle
        r_d.status = (r_q.status & ~clr) | set;
        r_d.gpr[0] = 32'h0000_0000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0;
            r_q.st <= ST_IDLE;
            r_q.pc <= PC_RESET;
            r_q.mode <= MODE_RESET;
            r_q.mask <= MASK_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    assign prdata = r_q.prdata;
    assign pslverr = r_q.pslverr && psel && penable;
    assign pready = psel && penable;
    assign dmem_req = r_q.req;
    assign dmem_addr = r_q.maddr;
    assign pc_out = r_q.pc;
    assign compressed_mode_flag = r_q.mode;
    assign irq = |(r_q.status & r_q.mask);

endmodule

// ===== tb/cisa_exec_properties.sv
// port-level assertions for the execute block
`timescale 1ns/1ns
module cisa_exec_checker
    import cisa_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // data memory
    input wire logic dmem_req,
    input wire logic [31:0] dmem_addr,
    input wire logic dmem_ack,
    // state
    input wire logic [31:0] pc_out,
    input wire logic compressed_mode_flag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // issue is only legal while no load is out
    wire wr_ins = psel && penable && pwrite && paddr == OFS_INSTR && !dmem_req;
    wire m16 = compressed_mode_flag && pwdata[31:27] != EXTEND_PREFIX;
    wire rjmp = m16 && pwdata[15:11] == REG_REG_MAJOR_OP && pwdata[4:0] == JUMP_FUNC;
    wire ld = m16 && pwdata[15:11] == BYTE_LOAD_OP;
    property p_compact;
        wr_ins && rjmp && pwdata[DELAY_SKIP_BIT] |=> !pc_out[0] ##1 $stable(pc_out);
    endproperty
    a_compact: assert property (p_compact) else $error("compact jump pc odd or moved again");
    property p_delayed;
        wr_ins && rjmp && !pwdata[DELAY_SKIP_BIT] |=> pc_out == $past(pc_out) + LEN_SHORT;
    endproperty
    a_delayed: assert property (p_delayed) else $error("delayed jump redirected too early");
    property p_swap;
        wr_ins && !compressed_mode_flag && pwdata[31:26] == MODE_SWAP_CALL_OP && !pc_out[1]
            |=> pc_out == $past(pc_out) + LEN_LONG && !compressed_mode_flag;
    endproperty
    a_swap: assert property (p_swap) else $error("mode swap call did not step to its slot");
    property p_fault;
        wr_ins && !compressed_mode_flag && pc_out[1] |=> $stable(pc_out) && !compressed_mode_flag;
    endproperty
    a_fault: assert property (p_fault) else $error("misaligned fetch still executed");
    property p_req;
        wr_ins && ld |-> ##[1:2] dmem_req;
    endproperty
    a_req: assert property (p_req) else $error("byte load issued no request");
    property p_req_src;
        $rose(dmem_req) |-> $past(wr_ins) || $past(wr_ins, 2);
    endproperty
    a_req_src: assert property (p_req_src) else $error("request without an issued load");
    property p_addr_hold;
        dmem_req && $past(dmem_req) |-> $stable(dmem_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("load address moved during request");
    property p_ack_end;
        dmem_ack |-> ##[1:2] !dmem_req;
    endproperty
    a_ack_end: assert property (p_ack_end) else $error("request held after answer");
    property p_ready;
        psel |-> pready == penable;
    endproperty
    a_ready: assert property (p_ready) else $error("apb ready not in access phase");
    property p_misalign;
        psel && penable && paddr[1:0] != 2'h0 |-> pslverr;
    endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned apb access not refused");
endmodule

bind cisa_exec cisa_exec_checker cisa_exec_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .dmem_req(dmem_req), .dmem_addr(dmem_addr), .dmem_ack(dmem_ack), .pc_out(pc_out),
    .compressed_mode_flag(compressed_mode_flag));

// ===== tb/mem_model.sv
// data memory partner with adjustable answer latency
`timescale 1ns/1ns
module mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request side
    input wire logic req,
    input wire logic [31:0] addr,
    input wire logic [3:0] lat,
    // answer side
    output logic ack,
    output logic [31:0] rdata
);
    logic [3:0] cnt;
    logic done;
    // data flips outside the answer cycle so a late sample cannot match
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
            done <= 1'b0;
            ack <= 1'b0;
            rdata <= 32'h0;
        end else begin
            ack <= 1'b0;
            rdata <= ~rdata;
            if (!req) begin
                cnt <= 4'h0;
                done <= 1'b0;
            end else if (!done && cnt >= lat) begin
                ack <= 1'b1;
                done <= 1'b1;
                rdata <= 32'h80F17F2C ^ {4{addr[9:2]}};
            end else if (!done) begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

// ===== tb/tb.sv
// self-checking bench for the execute block
`timescale 1ns/1ns
module tb;
    import cisa_pkg::*;
    typedef struct packed {
        logic [1:0] ctrl; logic ld; logic [4:0] r; logic [31:0] v; logic [31:0] ins;
        logic [31:0] pc; logic m; logic [4:0] xr; logic [31:0] xv;
    } row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dmem_req, dmem_ack, compressed_mode_flag, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, dmem_addr, dmem_rdata, pc_out, last_addr, d, st, pa, w;
    logic [1:0] ln;
    logic [3:0] lat;
    int failures, cmp_count;
    row_t rows [10];

    cisa_exec cisa_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dmem_req(dmem_req),
        .dmem_addr(dmem_addr), .dmem_ack(dmem_ack), .dmem_rdata(dmem_rdata), .pc_out(pc_out),
        .compressed_mode_flag(compressed_mode_flag), .irq(irq));
    mem_model mem_model_inst (.clk(pclk), .rst_n(presetn), .req(dmem_req), .addr(dmem_addr), .lat(lat),
        .ack(dmem_ack), .rdata(dmem_rdata));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) if (dmem_req) last_addr <= dmem_addr;

    function automatic logic [11:0] gpr(input logic [4:0] n);
        return OFS_GPR | {5'h00, n, 2'h0};
    endfunction
    task automatic apb(input logic wt, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r,
        output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wt;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] r;
        logic er;
        apb(1'b1, a, wd, r, er);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic er;
        apb(1'b0, a, 32'h0, r, er);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
            failures++;
        end
    endtask
    task automatic exe(input logic [31:0] ins, output logic [31:0] s);
        logic [31:0] r;
        wr(OFS_STATUS, 32'h7);
        wr(OFS_INSTR, ins);
        do begin
            rd(OFS_STATE, r);
        end while (r[0] !== 1'b0);
        rd(OFS_STATUS, s);
    endtask
    task automatic dly(input logic m0, input logic [31:0] pc0, input logic [4:0] r, input logic [31:0] v,
        input logic [31:0] ins, input logic [31:0] pc1, input logic [31:0] x31, input logic [31:0] tgt,
        input logic tm);
        wr(OFS_MODE, {31'h0, m0});
        wr(OFS_PC, pc0);
        wr(gpr(r), v);
        exe(ins, st);
        chk(pc_out, pc1);
        rd(gpr(5'h1F), d);
        chk(d, x31);
        rd(OFS_STATE, d);
        chk(d[1], 1'b1);
        wr(OFS_MODE, 32'h1);
        // slot is a short non-branch instruction
        exe(32'h835F, st);
        chk(pc_out, tgt);
        chk(compressed_mode_flag, tm);
    endtask
    task automatic stop_test;
        if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        stop_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, lat, failures, cmp_count} = '0;
        rows = '{'{2'h0, 1'b0, 5'h1F, 32'h1235, 32'hE8A0, 32'h1234, 1'b1, 5'h1F, 32'h1235},
            '{2'h0, 1'b0, 5'h10, 32'h20000010, 32'hE8C0, 32'h20000010, 1'b0, 5'h1F, 32'h103},
            '{2'h0, 1'b0, 5'h11, 32'h402, 32'hE980, 32'h402, 1'b0, 5'h11, 32'h402},
            '{2'h0, 1'b0, 5'h05, 32'hA07, 32'hED80, 32'hA06, 1'b1, 5'h05, 32'hA07},
            '{2'h0, 1'b1, 5'h03, 32'h10000002, 32'h835F, 32'h102, 1'b1, 5'h02, 32'h10000021},
            '{2'h1, 1'b1, 5'h03, 32'h10000002, 32'h835F, 32'h102, 1'b1, 5'h02, 32'h10000021},
            '{2'h2, 1'b1, 5'h03, 32'h10000002, 32'h835F, 32'h102, 1'b1, 5'h02, 32'h10000021},
            '{2'h3, 1'b1, 5'h03, 32'h10000002, 32'h835F, 32'h102, 1'b1, 5'h02, 32'h10000021},
            '{2'h1, 1'b1, 5'h03, 32'h10000002, 32'hF7FF839C, 32'h104, 1'b1, 5'h04, 32'h0FFFFFFE},
            '{2'h3, 1'b1, 5'h11, 32'h3, 32'h8100, 32'h102, 1'b1, 5'h10, 32'h3}};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk(pc_out, PC_RESET);
        chk(compressed_mode_flag, MODE_RESET);
        chk(irq, 1'b0);
        rd(OFS_MASK, d);
        chk(d, MASK_RESET);
        wr(OFS_MASK, 32'h7);
        foreach (rows[i]) begin
            lat <= 4'(i % 4);
            wr(OFS_CTRL, {30'h0, rows[i].ctrl});
            wr(OFS_MODE, 32'h1);
            wr(OFS_PC, 32'h100);
            wr(gpr(rows[i].r), rows[i].v);
            exe(rows[i].ins, st);
            chk(pc_out, rows[i].pc);
            chk(compressed_mode_flag, rows[i].m);
            chk(st[ST_ADDR_ERR_BIT], 1'b0);
            rd(gpr(rows[i].xr), d);
            if (rows[i].ld) begin
                pa = {rows[i].xv[31:2], rows[i].xv[1:0] ^ {2{rows[i].ctrl[CTRL_BYTE_SWAP_BIT]}}};
                ln = rows[i].xv[1:0] ^ {2{rows[i].ctrl[CTRL_MSB_FIRST_BIT]}};
                w = 32'h80F17F2C ^ {4{pa[9:2]}};
                chk(d, {{24{w[8 * ln + 7]}}, w[8 * ln +: 8]});
                chk(last_addr, pa);
            end else begin
                chk(d, rows[i].xv);
            end
        end
        dly(1'b1, 32'h200, 5'h1F, 32'h501, 32'hE820, 32'h202, 32'h501, 32'h500, 1'b1);
        dly(1'b1, 32'h300, 5'h04, 32'h700, 32'hEC40, 32'h302, 32'h305, 32'h700, 1'b0);
        dly(1'b0, 32'h0FFFFFFC, 5'h03, 32'h10000002, 32'h74000040, 32'h10000000, 32'h10000004, 32'h10000100,
            1'b1);
        wr(OFS_MODE, 32'h1);
        wr(gpr(5'h11), 32'h402);
        exe(32'hE980, st);
        chk(st[ST_ADDR_ERR_BIT], 1'b0);
        exe(32'h74000040, st);
        chk(st[ST_ADDR_ERR_BIT], 1'b1);
        chk(pc_out, 32'h402);
        @(negedge pclk);
        chk(irq, 1'b1);
        wr(OFS_MASK, 32'h0);
        @(negedge pclk);
        chk(irq, 1'b0);
        wr(OFS_MASK, 32'h7);
        wr(OFS_STATUS, 32'h7);
        @(negedge pclk);
        chk(irq, 1'b0);
        wr(OFS_PC, 32'h400);
        exe(32'h0, st);
        chk(st[ST_BAD_OP_BIT], 1'b1);
        // slow answer keeps the load out while a register write is tried
        lat <= 4'h8;
        wr(OFS_MODE, 32'h1);
        wr(OFS_INSTR, 32'h835F);
        wr(gpr(5'h05), 32'h0);
        exe(32'hED80, st);
        rd(gpr(5'h05), d);
        chk(d, 32'hA07);
        apb(1'b0, 12'h040, 32'h0, d, e);
        chk({d[31:1], e}, 32'h1);
        apb(1'b1, 12'h006, 32'h5, d, e);
        chk(e, 1'b1);
        apb(1'b1, 12'h086, 32'h5, d, e);
        chk(e, 1'b1);
        rd(gpr(5'h01), d);
        chk(d, 32'h0);
        wr(gpr(5'h00), 32'hFFFFFFFF);
        rd(gpr(5'h00), d);
        chk(d, 32'h0);
        stop_test();
    end
endmodule
